// *** hw/tcf_top.sv ***
`timescale 1ns/1ps
module tcf_top #(
    parameter int CNT_W = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] subAddr,
    input wire logic [1:0] winSel,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData,
    input wire logic timerRun,
    input wire logic upDownMode,
    input wire logic countingDown,
    input wire logic endOfCycle,
    input wire logic [CNT_W-1:0] count,
    input wire logic [CNT_W-1:0] reload,
    input wire logic [tcf_pkg::NUM_CH-1:0] chanIn,
    output logic [tcf_pkg::NUM_CH-1:0] chanOut,
    output logic [tcf_pkg::NUM_CH-1:0] chanIrq
);
    localparam int N = tcf_pkg::NUM_CH;

    logic [7:0] ctrl [N];
    logic [CNT_W-1:0] value [N];
    logic [CNT_W-1:0] pending [N];
    logic [N-1:0] pendValid;
    logic [N-1:0] flags;
    logic [N-1:0] chEvent;
    logic [N-1:0] capStrobe;
    logic [N-1:0] ieVec;
    logic [N-1:0] ueVec;
    logic [N-1:0] rsvdVec;
    logic [2:0] hitInfo;
    logic chHit;
    logic [1:0] chIdx;
    logic wrCtrl;
    logic wrHigh;
    logic wrLow;
    logic wrStatus;
    logic [N-1:0] clearMask;

    // =========================================================
    // Register decode
    assign hitInfo = tcf_pkg::tcf_ch_index(subAddr);
    assign chHit = hitInfo[2];
    assign chIdx = hitInfo[1:0];
    assign wrCtrl = wrEn && chHit && (winSel == tcf_pkg::WIN_CTRL);
    assign wrHigh = wrEn && chHit && (winSel == tcf_pkg::WIN_HIGH);
    assign wrLow = wrEn && chHit && (winSel == tcf_pkg::WIN_LOW);
    assign wrStatus = wrEn && (winSel == tcf_pkg::WIN_LOW) && (subAddr == tcf_pkg::SUB_STATUS);
    assign clearMask = wrStatus ? wrData[N-1:0] : '0;

    // =========================================================
    // Channel control registers
    always_ff @(posedge clock) begin
        for (int i = 0; i < N; i++) begin
            if (!rst_n) begin
                ctrl[i] <= tcf_pkg::CTL_RESET;
            end else if (wrCtrl && chIdx == 2'(i)) begin
                ctrl[i] <= wrData & tcf_pkg::CTL_WR_MASK;
            end
        end
    end

    // =========================================================
    // Capture/compare values with end-of-cycle buffering
    always_ff @(posedge clock) begin
        for (int i = 0; i < N; i++) begin
            if (!rst_n) begin
                value[i] <= tcf_pkg::VAL_RESET;
                pending[i] <= tcf_pkg::VAL_RESET;
                pendValid[i] <= 1'b0;
            end else if (capStrobe[i]) begin
                value[i] <= count;
                pendValid[i] <= 1'b0;
            end else if ((wrHigh || wrLow) && chIdx == 2'(i)) begin
                if (timerRun && !ueVec[i]) begin
                    pending[i] <= tcf_pkg::tcf_merge(pendValid[i] ? pending[i] : value[i],
                                                     wrData, wrHigh);
                    pendValid[i] <= 1'b1;
                end else begin
                    value[i] <= tcf_pkg::tcf_merge(value[i], wrData, wrHigh);
                    pendValid[i] <= 1'b0;
                end
            end else if (pendValid[i] && (endOfCycle || !timerRun)) begin
                value[i] <= pending[i];
                pendValid[i] <= 1'b0;
            end
        end
    end

    // =========================================================
    // Event flags and interrupts
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flags <= '0;
        end else if (!timerRun) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clearMask) | chEvent;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            chanIrq <= '0;
        end else begin
            chanIrq <= chEvent & ieVec;
        end
    end

    // =========================================================
    // Read port
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdData <= tcf_pkg::RD_NONE;
        end else if (rdEn) begin
            rdData <= tcf_pkg::RD_NONE;
            if (chHit) begin
                unique case (winSel)
                    tcf_pkg::WIN_HIGH: rdData <= value[chIdx][15:8];
                    tcf_pkg::WIN_LOW: rdData <= value[chIdx][7:0];
                    tcf_pkg::WIN_CTRL: rdData <= ctrl[chIdx];
                    default: rdData <= tcf_pkg::RD_NONE;
                endcase
            end else if (winSel == tcf_pkg::WIN_LOW && subAddr == tcf_pkg::SUB_STATUS) begin
                rdData <= {{(8 - N){1'b0}}, flags};
            end
        end
    end

    // =========================================================
    // Channels
    for (genvar g = 0; g < N; g++) begin : gCh
        assign ieVec[g] = ctrl[g][tcf_pkg::CTL_IE];
        assign ueVec[g] = ctrl[g][tcf_pkg::CTL_UE];
        assign rsvdVec[g] = ctrl[g][tcf_pkg::CTL_RSVD];
        tcf_channel #(
            .CNT_W(CNT_W)
        ) uChannel (
            .clock(clock),
            .rst_n(rst_n),
            .chanOn(ctrl[g][tcf_pkg::CTL_ON]),
            .chanPolarity(ctrl[g][tcf_pkg::CTL_POL]),
            .modeSel(ctrl[g][tcf_pkg::CTL_MODE_MSB:tcf_pkg::CTL_MODE_LSB]),
            .timerRun(timerRun),
            .upDownMode(upDownMode),
            .countingDown(countingDown),
            .count(count),
            .reload(reload),
            .compareValue(value[g]),
            .chanIn(chanIn[g]),
            .chanOut(chanOut[g]),
            .chanEvent(chEvent[g]),
            .captureStrobe(capStrobe[g])
        );
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_FLAG_SET: assert property (timerRun && chEvent != '0
        |=> (flags & $past(chEvent)) == $past(chEvent)) else $error("event flag not set");
    AST_FLAG_NO_IE: assert property (timerRun && (chEvent & ~ieVec) != '0
        |=> (flags & $past(chEvent & ~ieVec)) == $past(chEvent & ~ieVec))
        else $error("flag missed with irq disabled");
    AST_FLAG_CLEAR: assert property (timerRun && wrStatus && chEvent == '0
        |=> flags == ($past(flags) & ~$past(wrData[N-1:0]))) else $error("flag clear wrong");
    AST_FLAG_RACE: assert property (timerRun && (clearMask & chEvent) != '0
        |=> (flags & $past(clearMask & chEvent)) != '0) else $error("event lost on clear");
    AST_FLAG_IDLE: assert property (!timerRun |=> flags == '0)
        else $error("flags not held clear");
    AST_CTRL_RSVD: assert property (rsvdVec == '0)
        else $error("reserved control bit set");
    AST_CTRL_WR: assert property (wrCtrl && chIdx == 2'd0
        |=> ctrl[0] == ($past(wrData) & tcf_pkg::CTL_WR_MASK)) else $error("control write lost");
    AST_IRQ: assert property ((chEvent & ieVec) != '0
        |=> chanIrq == $past(chEvent & ieVec)) else $error("channel irq missing");
    AST_BUF_HOLD: assert property (timerRun && !ueVec[0] && (wrHigh || wrLow)
        && chIdx == 2'd0 && !capStrobe[0]
        ##1 timerRun && !endOfCycle && !capStrobe[0] && !wrHigh && !wrLow
        |=> value[0] == $past(value[0], 2)) else $error("buffered write applied early");

    // =========================================================
    // Register, buffering and interrupt checks
    AST_CTRL_READ: assert property (rdEn && chHit && winSel == tcf_pkg::WIN_CTRL
        |=> rdData == $past(ctrl[chIdx])) else $error("control read wrong");
    AST_VALUE_READ: assert property (rdEn && chHit && winSel == tcf_pkg::WIN_HIGH
        |=> rdData == $past(value[chIdx][15:8])) else $error("value high byte read wrong");
    AST_STATUS_READ: assert property (rdEn && !chHit && winSel == tcf_pkg::WIN_LOW
        && subAddr == tcf_pkg::SUB_STATUS
        |=> rdData[7:N] == '0 && rdData[N-1:0] == $past(flags)) else $error("status read wrong");
    AST_UNMAPPED_WR: assert property (wrEn && !chHit && winSel == tcf_pkg::WIN_CTRL
        |=> ctrl[0] == $past(ctrl[0]) && ctrl[N-1] == $past(ctrl[N-1]))
        else $error("unmapped write changed control");
    AST_DIRECT_WR: assert property ((!timerRun || ueVec[0]) && wrLow && chIdx == 2'd0
        && !capStrobe[0] |=> value[0][7:0] == $past(wrData)) else $error("direct write lost");
    AST_HIGH_BYTE: assert property ((!timerRun || ueVec[0]) && wrHigh && chIdx == 2'd0
        && !capStrobe[0] |=> value[0][15:8] == $past(wrData)) else $error("high byte lost");
    AST_PEND_HELD: assert property (timerRun && !ueVec[0] && wrLow && chIdx == 2'd0
        && !capStrobe[0] |=> pendValid[0] && pending[0][7:0] == $past(wrData))
        else $error("buffered write not held");
    AST_BUF_LOAD: assert property (pendValid[0] && endOfCycle && !capStrobe[0]
        && !((wrHigh || wrLow) && chIdx == 2'd0)
        |=> value[0] == $past(pending[0])) else $error("pending value not loaded");
    AST_CAP_VALUE: assert property (capStrobe[N-1]
        |=> value[N-1] == $past(count) && !pendValid[N-1]) else $error("capture value wrong");
    AST_IRQ_QUIET: assert property ((chEvent & ieVec) == '0
        |=> chanIrq == '0) else $error("channel irq without event");
    AST_FLAG_KEEP: assert property (timerRun && !wrStatus && chEvent == '0
        |=> flags == $past(flags)) else $error("flag changed without cause");

    COV_FLAG_CLEAR: cover property (wrStatus && flags != '0);
    COV_BUF_LOAD: cover property (pendValid[0] && endOfCycle);
endmodule

// *** hw/tcf_pkg.sv ***
package tcf_pkg;
    localparam int NUM_CH = 4;
    localparam logic [7:0] SUB_STATUS = 8'h01;
    localparam logic [7:0] SUB_CH_FIRST = 8'h02;
    localparam logic [7:0] SUB_CH_LAST = 8'h05;
    localparam logic [1:0] WIN_HIGH = 2'h0;
    localparam logic [1:0] WIN_LOW = 2'h1;
    localparam logic [1:0] WIN_CTRL = 2'h2;
    localparam int CTL_ON = 7;
    localparam int CTL_POL = 6;
    localparam int CTL_IE = 5;
    localparam int CTL_UE = 4;
    localparam int CTL_RSVD = 3;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_MODE_MSB = 2;
    localparam logic [7:0] CTL_WR_MASK = 8'hF7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] VAL_RESET = 16'h0000;
    localparam logic [7:0] RD_NONE = 8'h00;

    typedef enum logic [2:0] {
        MODE_ONESHOT = 3'b000,
        MODE_CONT = 3'b001,
        MODE_PWM = 3'b010,
        MODE_CAPTURE = 3'b011
    } tcf_mode_t;

    // Channel hit in bit 2, channel index in bits 1:0
    function automatic logic [2:0] tcf_ch_index(input logic [7:0] sub);
        logic [7:0] off;
        off = sub - SUB_CH_FIRST;
        tcf_ch_index = {(sub >= SUB_CH_FIRST) && (sub <= SUB_CH_LAST), off[1:0]};
    endfunction

    // Replaces the high or low byte of a 16-bit value
    function automatic logic [15:0] tcf_merge(input logic [15:0] old, input logic [7:0] data,
                                             input logic high);
        tcf_merge = high ? {data, old[7:0]} : {old[15:8], data};
    endfunction
endpackage

// *** hw/tcf_channel.sv ***
`timescale 1ns/1ps
module tcf_channel #(
    parameter int CNT_W = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chanOn,
    input wire logic chanPolarity,
    input wire logic [2:0] modeSel,
    input wire logic timerRun,
    input wire logic upDownMode,
    input wire logic countingDown,
    input wire logic [CNT_W-1:0] count,
    input wire logic [CNT_W-1:0] reload,
    input wire logic [CNT_W-1:0] compareValue,
    input wire logic chanIn,
    output logic chanOut,
    output logic chanEvent,
    output logic captureStrobe
);
    tcf_pkg::tcf_mode_t mode;
    logic inPrev;
    logic match;
    logic reloadHit;
    logic edgeSeen;

    assign mode = tcf_pkg::tcf_mode_t'(modeSel);
    assign match = timerRun && (count == compareValue);
    assign reloadHit = timerRun && (count == reload);
    assign edgeSeen = chanPolarity ? (inPrev && !chanIn) : (!inPrev && chanIn);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            inPrev <= 1'b0;
        end else begin
            inPrev <= chanIn;
        end
    end

    // =========================================================
    // Events
    always_comb begin
        chanEvent = 1'b0;
        captureStrobe = 1'b0;
        if (chanOn) begin
            unique case (modeSel)
                3'b000, 3'b001, 3'b010: begin
                    chanEvent = match;
                end
                3'b011: begin
                    chanEvent = timerRun && edgeSeen;
                    captureStrobe = timerRun && edgeSeen;
                end
                default: begin
                    chanEvent = 1'b0;
                end
            endcase
        end
    end

    // =========================================================
    // Output pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            chanOut <= 1'b0;
        end else begin
            unique case (mode)
                tcf_pkg::MODE_ONESHOT: begin
                    chanOut <= chanPolarity ^ (chanOn && match);
                end
                tcf_pkg::MODE_CONT: begin
                    if (!chanOn) begin
                        chanOut <= chanPolarity;
                    end else if (match) begin
                        chanOut <= !chanOut;
                    end
                end
                tcf_pkg::MODE_PWM: begin
                    if (!chanOn) begin
                        chanOut <= 1'b0;
                    end else if (upDownMode) begin
                        if (match) begin
                            chanOut <= !countingDown;
                        end
                    end else if (reloadHit) begin
                        chanOut <= 1'b0;
                    end else if (match) begin
                        chanOut <= 1'b1;
                    end
                end
                default: begin
                    chanOut <= chanPolarity;
                end
            endcase
        end
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_OFF_LEVEL: assert property ((modeSel == 3'b000 || modeSel == 3'b001) && !chanOn
        |=> chanOut == $past(chanPolarity)) else $error("disabled output not at polarity");
    AST_ONESHOT_PULSE: assert property (modeSel == 3'b000 && chanOn && match
        ##1 modeSel == 3'b000 && chanOn && !match && $stable(chanPolarity)
        |-> chanOut != chanPolarity ##1 chanOut == $past(chanPolarity))
        else $error("one-shot pulse not one clock");
    AST_CONT_TOGGLE: assert property (modeSel == 3'b001 && chanOn && match
        |=> chanOut != $past(chanOut)) else $error("continuous output did not invert");
    AST_PWM_OFF: assert property (modeSel == 3'b010 && !chanOn
        |=> !chanOut) else $error("disabled PWM output not low");
    AST_PWM_MOD: assert property (modeSel == 3'b010 && chanOn && !upDownMode
        |=> chanOut == ($past(reloadHit) ? 1'b0 : ($past(match) ? 1'b1 : $past(chanOut))))
        else $error("PWM modulo edge wrong");
    AST_PWM_UPDN: assert property (modeSel == 3'b010 && chanOn && upDownMode && match
        |=> chanOut == !$past(countingDown)) else $error("PWM up/down edge wrong");
    AST_CAPTURE: assert property (modeSel == 3'b011 && chanOn && timerRun
        && $past(chanIn) == chanPolarity && chanIn == !chanPolarity |-> captureStrobe)
        else $error("capture edge missed");

    COV_ONESHOT: cover property (modeSel == 3'b000 && chanOn && match);
    COV_PWM_HIGH: cover property (modeSel == 3'b010 && chanOn && $rose(chanOut));
    COV_CAPTURE: cover property (captureStrobe);
endmodule

// *** test/tcf_pin_model.sv ***
`timescale 1ns/1ps
// ============================================================
// Channel input pins driven by outside circuitry
module tcf_pin_model (
    input wire logic clock,
    input wire logic [3:0] pinLevel,
    output logic [3:0] chanIn
);
    initial chanIn = 4'h0;
    // Pins move well clear of the sampling edge
    always @(posedge clock) begin
        chanIn <= #10 pinLevel;
    end
endmodule

// *** test/test_tcf_top.sv ***
`timescale 1ns/1ps
module test_tcf_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] subAddr = 8'h00;
    logic [7:0] wrData = 8'h00;
    logic [1:0] winSel = 2'h0;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic timerRun = 1'b0;
    logic upDownMode = 1'b0;
    logic countingDown = 1'b0;
    logic endOfCycle = 1'b0;
    logic [15:0] count = 16'h0000;
    logic [15:0] reload = 16'h0040;
    logic [3:0] pinLevel = 4'h0;
    logic [3:0] chanIn;
    logic [3:0] chanOut;
    logic [3:0] chanIrq;
    logic [7:0] rdData;
    int failures = 0;
    int compares = 0;

    always #20 clock = ~clock;

    tcf_pin_model i_tcf_pin_model (.clock(clock), .pinLevel(pinLevel), .chanIn(chanIn));

    tcf_top i_tcf_top (.clock(clock), .rst_n(rst_n), .subAddr(subAddr), .winSel(winSel),
        .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData), .rdData(rdData), .timerRun(timerRun),
        .upDownMode(upDownMode), .countingDown(countingDown), .endOfCycle(endOfCycle),
        .count(count), .reload(reload), .chanIn(chanIn), .chanOut(chanOut),
        .chanIrq(chanIrq));

    // ============================================================
    // Shared tasks
    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] w, input logic [7:0] a, input logic [7:0] d);
        winSel = w;
        subAddr = a;
        wrData = d;
        wrEn = 1'b1;
        @(negedge clock);
        wrEn = 1'b0;
        @(negedge clock);
    endtask

    task automatic rd(input logic [1:0] w, input logic [7:0] a, input logic [7:0] exp);
        winSel = w;
        subAddr = a;
        rdEn = 1'b1;
        @(negedge clock);
        rdEn = 1'b0;
        check("rdData", rdData, exp);
        @(negedge clock);
    endtask

    // Sets the count for one match edge, then checks chanOut of the given channel
    task automatic hit(input logic [15:0] c, input int ch, input logic exp);
        count = c;
        @(negedge clock);
        check("chanOut", chanOut[ch], exp);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        for (int i = 2; i <= 5; i++) begin
            rd(2'h2, 8'(i), 8'h00);
        end
        rd(2'h1, 8'h01, 8'h00);
        wr(2'h2, 8'h02, 8'hFF);
        rd(2'h2, 8'h02, 8'hF7);
        wr(2'h2, 8'h06, 8'hFF);
        rd(2'h2, 8'h06, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(2'h0, 8'(i + 2), 8'h00);
            wr(2'h1, 8'(i + 2), 8'(16 * i + 16));
        end
        // One-shot channel A
        wr(2'h2, 8'h02, 8'h40);
        check("chanOut", chanOut[0], 1'b1);
        wr(2'h2, 8'h02, 8'h00);
        check("chanOut", chanOut[0], 1'b0);
        wr(2'h2, 8'h02, 8'hA0);
        timerRun = 1'b1;
        hit(16'h0010, 0, 1'b1);
        check("chanIrq", chanIrq, 4'h1);
        hit(16'h0011, 0, 1'b0);
        check("chanIrq", chanIrq, 4'h0);
        rd(2'h1, 8'h01, 8'h01);
        wr(2'h1, 8'h01, 8'h00);
        rd(2'h1, 8'h01, 8'h01);
        wr(2'h1, 8'h01, 8'h01);
        rd(2'h1, 8'h01, 8'h00);
        count = 16'h0010;
        winSel = 2'h1;
        subAddr = 8'h01;
        wrData = 8'h01;
        wrEn = 1'b1;
        @(negedge clock);
        wrEn = 1'b0;
        count = 16'h0011;
        @(negedge clock);
        rd(2'h1, 8'h01, 8'h01);
        timerRun = 1'b0;
        @(negedge clock);
        rd(2'h1, 8'h01, 8'h00);
        // Continuous compare channel B, interrupt off
        wr(2'h2, 8'h03, 8'h81);
        timerRun = 1'b1;
        hit(16'h0020, 1, 1'b1);
        check("chanIrq", chanIrq, 4'h0);
        hit(16'h0021, 1, 1'b1);
        hit(16'h0020, 1, 1'b0);
        rd(2'h1, 8'h01, 8'h02);
        // PWM channel C
        wr(2'h2, 8'h04, 8'h42);
        check("chanOut", chanOut[2], 1'b0);
        wr(2'h2, 8'h04, 8'hC2);
        hit(16'h0030, 2, 1'b1);
        hit(16'h0035, 2, 1'b1);
        hit(16'h0040, 2, 1'b0);
        upDownMode = 1'b1;
        hit(16'h0030, 2, 1'b1);
        countingDown = 1'b1;
        hit(16'h0030, 2, 1'b0);
        // Capture channel D
        timerRun = 1'b0;
        wr(2'h2, 8'h05, 8'h83);
        timerRun = 1'b1;
        count = 16'h1234;
        pinLevel = 4'h8;
        repeat (3) @(negedge clock);
        count = 16'h5678;
        pinLevel = 4'h0;
        repeat (3) @(negedge clock);
        rd(2'h0, 8'h05, 8'h12);
        rd(2'h1, 8'h05, 8'h34);
        rd(2'h1, 8'h01, 8'h08);
        wr(2'h2, 8'h05, 8'hC3);
        pinLevel = 4'h8;
        repeat (3) @(negedge clock);
        count = 16'h0ABC;
        pinLevel = 4'h0;
        repeat (3) @(negedge clock);
        rd(2'h0, 8'h05, 8'h0A);
        rd(2'h1, 8'h05, 8'hBC);
        // Buffered value write on channel A
        count = 16'h0000;
        wr(2'h1, 8'h02, 8'h50);
        hit(16'h0050, 0, 1'b0);
        endOfCycle = 1'b1;
        @(negedge clock);
        endOfCycle = 1'b0;
        hit(16'h0050, 0, 1'b1);
        final_report();
    end

    // ============================================================
    // Hang guard
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        final_report();
    end
endmodule
